// ---- hw/bsp_pkg.sv ----
// Constants, timing figures and state encoding for the step-down converter
// sequencing and protection controller.
// Assumes a single 125 MHz reference clock drives all of the logic.

package bsp_pkg;

	// ------------------------------------------------------------------
	// Clock and derived timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 8;      // Reference clock period.
	localparam int CNT_W           = 21;     // Width of the long timers.

	// Pseudo-constant switching frequency, longest period rounds down.
	localparam int SWITCH_KHZ      = 650;
	localparam int PERIOD_CYC      = 1000000 / (SWITCH_KHZ * CLK_PERIOD_NS);

	// Minimum off time of the high-side switch, a least time rounds up.
	localparam int MIN_OFF_NS      = 275;
	localparam int MIN_OFF_CYC     = (MIN_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Fixed on-time used after a current-limited cycle.
	localparam int FIXED_ON_NS     = 165;
	localparam int FIXED_ON_CYC    = (FIXED_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Soft-start ramp length.
	localparam int SS_TIME_US      = 1000;
	localparam int SS_CYC          = SS_TIME_US * 1000 / CLK_PERIOD_NS;

	// Undervoltage qualification in regulation and when starting into a short.
	localparam int UV_DEB_NS       = 10000;
	localparam int UV_DEB_CYC      = UV_DEB_NS / CLK_PERIOD_NS;
	localparam int HIC_DELAY_US    = 1300;
	localparam int HIC_DELAY_CYC   = HIC_DELAY_US * 1000 / CLK_PERIOD_NS;

	// Hiccup off time before a restart.
	localparam int HIC_OFF_US      = 10000;
	localparam int HIC_OFF_CYC     = HIC_OFF_US * 1000 / CLK_PERIOD_NS;

	// Serial input spike filter width.
	localparam int SPIKE_NS        = 32;
	localparam int SPIKE_CYC       = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ------------------------------------------------------------------
	// Current limit and rectifier phase-in
	// ------------------------------------------------------------------
	localparam logic [2:0]  OC_TRIP_COUNT = 3'h7;   // Consecutive limited cycles.
	localparam logic [15:0] LS_START_CYC  = 16'h0002; // First low-side pulse.
	localparam logic [15:0] LS_STEP_CYC   = 16'h0002; // Growth per cycle.
	localparam int          SS_REF_W      = 8;        // Reference ramp width.
	localparam logic [7:0]  SS_REF_MAX    = 8'hFF;    // Ramp end value.

	// ------------------------------------------------------------------
	// Pin vector layout after synchronisation
	// ------------------------------------------------------------------
	localparam int PIN_W      = 9;
	localparam int P_SDA      = 0;
	localparam int P_SCL      = 1;
	localparam int P_UV       = 2;
	localparam int P_CUR_LO   = 3;
	localparam int P_CUR_HI   = 4;
	localparam int P_REF_ABV  = 5;
	localparam int P_FDBK_LOW = 6;
	localparam int P_SUP_OK   = 7;
	localparam int P_ENABLE   = 8;

	// Converter phase.
	typedef enum logic [1:0] {
		BSP_OFF,
		BSP_HIGH,
		BSP_LOW,
		BSP_HICCUP
	} bsp_phase_t;

endpackage

// ---- hw/bsp_ctrl.sv ----
// Sequencing and protection controller of an adaptive on-time step-down
// converter: switch timing, soft start, pre-bias phase-in, valley current
// limit, hiccup, lockout and the serial input spike filter.
// Assumes all comparator outputs and voltage codes arrive asynchronously
// from the analog power stage and that the gate drivers add dead time.

`timescale 1ns/10ps

module bsp_ctrl
	import bsp_pkg::*;
#(
	parameter int SS_CYCLES    = SS_CYC,        // Soft-start length.
	parameter int HIC_DELAY    = HIC_DELAY_CYC, // Undervoltage wait in soft start.
	parameter int HIC_OFF      = HIC_OFF_CYC,   // Hiccup off time.
	parameter int CODE_W       = 8              // Width of voltage codes.
) (
	// Clock and reset.
	input  wire logic              ref_clk,
	input  wire logic              arst_n,
	// Control pins.
	input  wire logic              enable,
	input  wire logic              supply_ok,
	// Comparators of the power stage.
	input  wire logic              feedback_low,
	input  wire logic              ref_above_feedback,
	input  wire logic              current_over_high,
	input  wire logic              current_over_low,
	input  wire logic              undervoltage_trip,
	// Voltage codes for the on-time timer.
	input  wire logic [CODE_W-1:0] vin_code,
	input  wire logic [CODE_W-1:0] vout_code,
	// Raw serial pins.
	input  wire logic              scl_raw,
	input  wire logic              sda_raw,
	// Gate drive.
	output logic                   high_side_on,
	output logic                   low_side_on,
	// Status and reference.
	output logic [SS_REF_W-1:0]    soft_start_ref,
	output logic                   current_limit_level,
	output logic                   hiccup_active,
	output logic                   converter_on,
	// Filtered serial lines.
	output logic                   scl_clean,
	output logic                   sda_clean
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	localparam int SS_STEP = SS_CYCLES / (1 << SS_REF_W); // Cycles per ramp step.

	typedef struct packed {
		logic [PIN_W-1:0]      s1;        // First synchroniser stage.
		logic [PIN_W-1:0]      s2;        // Second synchroniser stage.
		logic [2*CODE_W-1:0]   c1;        // Codes, first stage.
		logic [2*CODE_W-1:0]   c2;        // Codes, second stage.
		logic [1:0][2:0]       flt_cnt;   // Spike filter counters.
		logic [1:0]            flt_out;   // Accepted serial levels.
		bsp_phase_t            phase;     // Converter phase.
		logic [15:0]           on_cnt;    // On-time remaining.
		logic [7:0]            off_cnt;   // Minimum off time remaining.
		logic [15:0]           low_el;    // Cycles spent in low phase.
		logic [15:0]           ls_width;  // Low-side pulse width.
		logic                  ls_full;   // Low side has full interval.
		logic                  rect_en;   // Synchronous rectification on.
		logic [SS_REF_W-1:0]   ss_ref;    // Reference ramp value.
		logic [CNT_W-1:0]      ss_div;    // Ramp step prescaler.
		logic [CNT_W-1:0]      uv_cnt;    // Undervoltage duration.
		logic [CNT_W-1:0]      hic_cnt;   // Hiccup off time remaining.
		logic [2:0]            oc_cnt;    // Consecutive limited cycles.
		logic                  limit_low; // Lower current limit chosen.
		logic                  fixed_on;  // Next on-time is fixed.
		logic                  cyc_act;   // Cycle exceeded active limit.
		logic                  cyc_lo;    // Cycle exceeded lower limit.
		logic                  hs;        // High-side gate.
		logic                  ls;        // Low-side gate.
		logic                  hic;       // Hiccup flag.
		logic                  active;    // Switching enabled.
	} bsp_state_t;

	bsp_state_t r;       // Registered state.
	bsp_state_t next_r;  // Next state.

	// Restart the soft-start sequence from zero, rectifier off.
	function automatic bsp_state_t bsp_restart(input bsp_state_t s);
		bsp_state_t t;
		t          = s;
		t.phase    = BSP_LOW;
		t.ss_ref   = '0;
		t.ss_div   = '0;
		t.rect_en  = 1'b0;
		t.ls_full  = 1'b0;
		t.ls_width = LS_START_CYC;
		t.uv_cnt   = '0;
		t.off_cnt  = '0;
		t.low_el   = '0;
		t.cyc_act  = 1'b0;
		t.cyc_lo   = 1'b0;
		return t;
	endfunction

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	// Decoded inputs and helpers.
	logic              run;
	logic              over_act;
	logic              start_cyc;
	logic              ss_done;
	logic [CODE_W-1:0] vin_s;
	logic [CODE_W-1:0] vout_s;
	logic [15:0]       prod;
	logic [15:0]       on_adapt;
	logic [CNT_W-1:0]  uv_limit;

	// One process computes the whole next state from the registered copy.
	always_comb begin
		next_r = r;
		// Two-flop synchronisers; only the second stage is read.
		next_r.s1 = {enable, supply_ok, feedback_low, ref_above_feedback,
			current_over_high, current_over_low, undervoltage_trip, scl_raw, sda_raw};
		next_r.s2 = r.s1;
		// Codes change slowly, so a per-bit skew settles within a cycle.
		next_r.c1 = {vin_code, vout_code};
		next_r.c2 = r.c1;

		// Spike filter: a level is accepted only after it differs for
		// more than the spike width of consecutive samples.
		for (int i = 0; i < 2; i++) begin
			if (r.s2[P_SDA + i] == r.flt_out[i]) begin
				next_r.flt_cnt[i] = '0;
			end else if (r.flt_cnt[i] == 3'(SPIKE_CYC)) begin
				next_r.flt_out[i] = r.s2[P_SDA + i];
				next_r.flt_cnt[i] = '0;
			end else begin
				next_r.flt_cnt[i] = r.flt_cnt[i] + 3'h1;
			end
		end

		run      = r.s2[P_ENABLE] & r.s2[P_SUP_OK];
		// The active limit follows the level chosen by the counter.
		over_act = r.limit_low ? r.s2[P_CUR_LO] : r.s2[P_CUR_HI];
		ss_done  = (r.ss_ref == SS_REF_MAX);
		vin_s    = r.c2[2*CODE_W-1:CODE_W];
		vout_s   = r.c2[CODE_W-1:0];

		// Adaptive on-time: nominal period scaled by the duty ratio.
		// The product fits 16 bits for 8-bit codes and the nominal period;
		// wider codes would need a wider product and quotient.
		prod = 16'(PERIOD_CYC) * 16'(vout_s);
		if (vin_s == '0) begin
			on_adapt = 16'(PERIOD_CYC);
		end else begin
			on_adapt = prod / 16'(vin_s);
		end
		if (on_adapt == '0) begin
			on_adapt = 16'h0001;
		end

		// A cycle starts when the off time has passed, current is below
		// the limit, and either feedback dropped or a limit ended the cycle.
		start_cyc = (r.off_cnt == '0) && !over_act &&
			(r.s2[P_FDBK_LOW] || r.cyc_act);

		// Starting into a short gets the long wait, else the short one.
		uv_limit = ss_done ? CNT_W'(UV_DEB_CYC) : CNT_W'(HIC_DELAY);

		unique case (r.phase)
			BSP_OFF: begin
				// Leave lockout through a fresh soft start.
				if (run) begin
					next_r = bsp_restart(r);
				end
			end
			BSP_HIGH: begin
				// High side runs until the on-time timer expires.
				if (r.on_cnt <= 16'h0001) begin
					next_r.phase   = BSP_LOW;
					next_r.off_cnt = 8'(MIN_OFF_CYC);
					next_r.low_el  = '0;
					next_r.cyc_act = 1'b0;
					next_r.cyc_lo  = 1'b0;
				end else begin
					next_r.on_cnt = r.on_cnt - 16'h0001;
				end
			end
			BSP_LOW: begin
				if (r.off_cnt != '0) begin
					next_r.off_cnt = r.off_cnt - 8'h01;
				end
				if (r.low_el != 16'hFFFF) begin
					next_r.low_el = r.low_el + 16'h0001;
				end
				// Remember which limits the valley current exceeded.
				next_r.cyc_act = r.cyc_act | over_act;
				next_r.cyc_lo  = r.cyc_lo | r.s2[P_CUR_LO];
				if (start_cyc) begin
					// Cycle-end bookkeeping of the current limit.
					if (r.cyc_act) begin
						next_r.fixed_on = 1'b1;
						if (r.oc_cnt != OC_TRIP_COUNT) begin
							next_r.oc_cnt = r.oc_cnt + 3'h1;
						end
						if (r.oc_cnt + 3'h1 == OC_TRIP_COUNT) begin
							next_r.limit_low = 1'b1;
						end
					end else begin
						next_r.fixed_on = 1'b0;
					end
					if (!r.cyc_lo) begin
						next_r.oc_cnt    = '0;
						next_r.limit_low = 1'b0;
					end
					// Widen the low-side pulse until it fills the interval.
					if (r.rect_en && !r.ls_full) begin
						if (r.low_el > r.ls_width) begin
							next_r.ls_width = r.ls_width + LS_STEP_CYC;
						end else begin
							next_r.ls_full = 1'b1;
						end
					end
					next_r.phase  = BSP_HIGH;
					next_r.on_cnt = next_r.fixed_on ?
						16'(FIXED_ON_CYC) : on_adapt;
				end
			end
			BSP_HICCUP: begin
				// Stay off, then retry through the full soft start.
				// The off time counts only here; a lockout clears it.
				if (r.hic_cnt <= CNT_W'(1)) begin
					next_r = bsp_restart(r);
				end else begin
					next_r.hic_cnt = r.hic_cnt - CNT_W'(1);
				end
			end
		endcase

		// Soft-start ramp and undervoltage watch while switching.
		// The ramp advances only while switching; every restart clears it
		// first, so a retry never resumes from a partial reference.
		if (r.phase == BSP_HIGH || r.phase == BSP_LOW) begin
			if (!ss_done) begin
				if (r.ss_div >= CNT_W'(SS_STEP - 1)) begin
					next_r.ss_div = '0;
					next_r.ss_ref = r.ss_ref + 1'b1;
				end else begin
					next_r.ss_div = r.ss_div + CNT_W'(1);
				end
			end
			// Rectifier waits until the reference passes the pre-bias.
			// It is switched on only in a high phase, so the first low-side
			// pulse starts at the top of a low phase at its narrowest, and a
			// partial low phase never widens the pulse before it is used.
			if (r.s2[P_REF_ABV] && r.phase == BSP_HIGH) begin
				next_r.rect_en = 1'b1;
			end
			if (r.s2[P_UV]) begin
				if (r.uv_cnt + CNT_W'(1) >= uv_limit) begin
					next_r.phase   = BSP_HICCUP;
					next_r.hic_cnt = CNT_W'(HIC_OFF);
					next_r.uv_cnt  = '0;
				end else begin
					next_r.uv_cnt = r.uv_cnt + CNT_W'(1);
				end
			end else begin
				next_r.uv_cnt = '0;
			end
		end

		// Lockout or disable wins over everything; nothing is latched.
		if (!run) begin
			next_r.phase   = BSP_OFF;
			next_r.ss_ref  = '0;
			next_r.rect_en = 1'b0;
			next_r.uv_cnt  = '0;
			next_r.hic_cnt = '0;
			next_r.off_cnt = '0;
		end

		// Registered gate and status outputs follow the next phase.
		// The low side is also forced on while the active limit is exceeded in a low phase after its
		// first cycle, even before rectification starts, so only that first cycle can leave a valley open.
		next_r.hs     = (next_r.phase == BSP_HIGH);
		next_r.ls     = (next_r.phase == BSP_LOW) &&
			((next_r.rect_en && (next_r.ls_full || next_r.low_el < next_r.ls_width))
			|| (over_act && r.phase == BSP_LOW));
		next_r.hic    = (next_r.phase == BSP_HICCUP);
		next_r.active = (next_r.phase == BSP_HIGH) || (next_r.phase == BSP_LOW);
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	// The serial lines idle high, so the filter starts accepting high.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			r          <= '0;
			r.phase    <= BSP_OFF;
			r.flt_out  <= 2'h3;
			r.ls_width <= LS_START_CYC;
			// Serial synchroniser stages start at the idle level, so the
			// filter does not count reset zeros as the start of a spike.
			r.s1[P_SCL] <= 1'b1;
			r.s1[P_SDA] <= 1'b1;
			r.s2[P_SCL] <= 1'b1;
			r.s2[P_SDA] <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// ------------------------------------------------------------------
	// Outputs, straight from the state register
	// ------------------------------------------------------------------
	assign high_side_on        = r.hs;
	assign low_side_on         = r.ls;
	assign soft_start_ref      = r.ss_ref;
	assign current_limit_level = r.limit_low;
	assign hiccup_active       = r.hic;
	assign converter_on        = r.active;
	assign scl_clean           = r.flt_out[1];
	assign sda_clean           = r.flt_out[0];

endmodule

// ---- tb/bsp_ctrl_monitor.sv ----
// Port checker for the converter sequencing and protection controller.
// Assumes it is bound to bsp_ctrl and handed the hiccup off length.
`timescale 1ns/10ps
module bsp_ctrl_monitor
	import bsp_pkg::*;
#(
	parameter int HIC_OFF = HIC_OFF_CYC // Hiccup off time in cycles.
) (
	// Clock and reset.
	input wire logic                ref_clk,
	input wire logic                arst_n,
	// Inputs watched.
	input wire logic                enable,
	input wire logic                supply_ok,
	input wire logic                feedback_low,
	input wire logic                current_over_high,
	input wire logic                current_over_low,
	input wire logic                scl_raw,
	input wire logic                sda_raw,
	// Outputs watched.
	input wire logic                high_side_on,
	input wire logic                low_side_on,
	input wire logic [SS_REF_W-1:0] soft_start_ref,
	input wire logic                current_limit_level,
	input wire logic                hiccup_active,
	input wire logic                converter_on,
	input wire logic                scl_clean,
	input wire logic                sda_clean
);
	// --------------------------------------------------------------
	// Helper counters
	// --------------------------------------------------------------
	logic [5:0]  off_cnt; // Cycles the high side has been off, saturating.
	logic [15:0] hic_cnt; // Length of the running hiccup.

	// Starts saturated so that the first pulse after reset is not judged.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			off_cnt <= 6'h3F;
			hic_cnt <= 16'h0000;
		end else begin
			off_cnt <= high_side_on ? 6'h00 : off_cnt + {5'h00, off_cnt != 6'h3F};
			hic_cnt <= hiccup_active ? hic_cnt + 16'h0001 : 16'h0000;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	// --------------------------------------------------------------
	// Properties
	// --------------------------------------------------------------
	property p_no_overlap; !(high_side_on && low_side_on); endproperty
	a_no_overlap: assert property (p_no_overlap) else $error("both switches on");
	property p_min_off; $rose(high_side_on) |-> off_cnt >= 6'h23; endproperty
	a_min_off: assert property (p_min_off) else $error("off time too short");
	property p_cause;
		$rose(high_side_on) |-> $past(feedback_low, 3) || $past(current_over_high, 4)
			|| $past(current_over_low, 4);
	endproperty
	a_cause: assert property (p_cause) else $error("cycle without cause");
	property p_off; (!enable || !supply_ok) |-> ##[1:4] !converter_on; endproperty
	a_off: assert property (p_off) else $error("no shutdown");
	property p_hic_quiet; hiccup_active |-> !high_side_on && !low_side_on; endproperty
	a_hic_quiet: assert property (p_hic_quiet) else $error("switching in hiccup");
	property p_hic_len;
		$fell(hiccup_active) |-> hic_cnt >= HIC_OFF - 1 && hic_cnt <= HIC_OFF + 1;
	endproperty
	a_hic_len: assert property (p_hic_len) else $error("hiccup length wrong");
	property p_restart; $fell(hiccup_active) |-> soft_start_ref == 8'h00 && !low_side_on;
	endproperty
	a_restart: assert property (p_restart) else $error("restart not from zero");
	property p_ramp;
		converter_on && $past(converter_on) && !hiccup_active
			|-> 8'(soft_start_ref - $past(soft_start_ref)) <= 8'h01;
	endproperty
	a_ramp: assert property (p_ramp) else $error("ramp not monotonic");
	property p_scl_filt;
		$changed(scl_clean) |-> $past(scl_raw, 3) == scl_clean && $past(scl_raw, 4) == scl_clean
			&& $past(scl_raw, 5) == scl_clean && $past(scl_raw, 6) == scl_clean;
	endproperty
	a_scl_filt: assert property (p_scl_filt) else $error("clock spike passed");
	property p_sda_filt;
		$changed(sda_clean) |-> $past(sda_raw, 3) == sda_clean && $past(sda_raw, 4) == sda_clean
			&& $past(sda_raw, 5) == sda_clean && $past(sda_raw, 6) == sda_clean;
	endproperty
	a_sda_filt: assert property (p_sda_filt) else $error("data spike passed");

	c_hiccup: cover property ($rose(hiccup_active));
	c_level: cover property ($rose(current_limit_level));
	c_low: cover property ($rose(low_side_on));
endmodule

bind bsp_ctrl bsp_ctrl_monitor #(.HIC_OFF(HIC_OFF)) u_mon (.ref_clk, .arst_n, .enable,
	.supply_ok, .feedback_low, .current_over_high, .current_over_low, .scl_raw, .sda_raw,
	.high_side_on, .low_side_on, .soft_start_ref, .current_limit_level, .hiccup_active,
	.converter_on, .scl_clean, .sda_clean);

// ---- tb/bsp_stage_model.sv ----
// Behavioural power stage: comparators answering the controller's gates.
// Assumes the bench commands pre-bias, overload and short conditions.
`timescale 1ns/10ps
module bsp_stage_model #(
	parameter int SAG_DLY = 40 // Low-phase cycles until feedback sags.
) (
	// Clock and gate drive.
	input  wire logic ref_clk,
	input  wire logic high_side_on,
	input  wire logic converter_on,
	// Conditions set by the bench.
	input  wire logic prebias,
	input  wire logic overload,
	input  wire logic shorted,
	// Comparator outputs.
	output logic      feedback_low,
	output logic      ref_above_feedback,
	output logic      current_over_high,
	output logic      current_over_low,
	output logic      undervoltage_trip
);
	int   lo_cnt = 0; // Length of the running low phase.
	logic lo_run;     // Inside a low phase.

	initial begin
		{feedback_low, ref_above_feedback, current_over_high} = 3'h0;
		{current_over_low, undervoltage_trip} = 2'h0;
	end

	// Outputs move after the controller has sampled the edge's values.
	always @(posedge ref_clk) begin
		lo_run = converter_on && !high_side_on;
		lo_cnt = lo_run ? lo_cnt + 1 : 0;
		feedback_low <= lo_run && lo_cnt >= SAG_DLY;
		// An overload holds the valley current high for 49 cycles of each low phase.
		current_over_high <= overload && lo_run && lo_cnt < 50;
		current_over_low <= overload && lo_run && lo_cnt < 50;
		ref_above_feedback <= prebias;
		undervoltage_trip <= shorted;
	end
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the converter controller.
// Assumes the stage model answers the gates and the checker is bound.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin failures++; \
	$display("BAD %s exp %0h got %0h", nm, ex, got); end end
`define WAITC(c) for (wt = 0; !(c); wt++) if (wt > 30000) begin failures++; end_sim(); \
	end else @(negedge ref_clk);
module tb_top import bsp_pkg::*; ;
	localparam int SS = 512, HDLY = 200, HOFF = 300; // Shortened timings.
	logic       ref_clk = 1'b0, arst_n = 1'b0, enable = 1'b0, supply_ok = 1'b0;
	logic       scl_raw = 1'b1, sda_raw = 1'b1, prebias = 1'b0, overload = 1'b0;
	logic       shorted = 1'b0, feedback_low, ref_above_feedback, current_over_high;
	logic       current_over_low, undervoltage_trip, high_side_on, low_side_on;
	logic       current_limit_level, hiccup_active, converter_on, scl_clean, sda_clean;
	logic [7:0] vin_code = 8'h60, vout_code = 8'h20, soft_start_ref;
	int         failures = 0, n_compared = 0, wt, a;

	bsp_ctrl #(.SS_CYCLES(SS), .HIC_DELAY(HDLY), .HIC_OFF(HOFF)) DUT (.ref_clk, .arst_n,
		.enable, .supply_ok, .feedback_low, .ref_above_feedback, .current_over_high,
		.current_over_low, .undervoltage_trip, .vin_code, .vout_code, .scl_raw, .sda_raw,
		.high_side_on, .low_side_on, .soft_start_ref, .current_limit_level, .hiccup_active,
		.converter_on, .scl_clean, .sda_clean);
	bsp_stage_model u_stage (.ref_clk, .high_side_on, .converter_on, .prebias, .overload,
		.shorted, .feedback_low, .ref_above_feedback, .current_over_high, .current_over_low,
		.undervoltage_trip);

	always #4 ref_clk = ~ref_clk;

	// Measures the next high pulse of a gate (0 high side, 1 low side, 2 hiccup).
	task automatic pulse(input int s, output int w);
		`WAITC((s == 0 ? high_side_on : s == 1 ? low_side_on : hiccup_active) === 1'b0)
		`WAITC((s == 0 ? high_side_on : s == 1 ? low_side_on : hiccup_active) === 1'b1)
		`WAITC((s == 0 ? high_side_on : s == 1 ? low_side_on : hiccup_active) === 1'b0)
		w = wt;
	endtask

	task end_sim;
		$display("Compared %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// Four-sample spikes vanish, six-sample ones pass, on both serial lines.
	task automatic t_filter;
		logic seen;
		for (int s = 0; s < 2; s++) begin
			for (int w = 4; w <= 6; w += 2) begin
				seen = 1'b0;
				if (s == 0) scl_raw = 1'b0;
				else sda_raw = 1'b0;
				for (int i = 0; i < 16; i++) begin
					if (i == w) {scl_raw, sda_raw} = 2'h3;
					seen |= !(s == 0 ? scl_clean : sda_clean);
					@(negedge ref_clk);
				end
				`CHK("filter", w == 6, seen)
			end
		end
	endtask

	// Ramp length, then rectifier held off until prebias is raised, then phased in.
	task automatic t_start;
		logic seen;
		{enable, supply_ok} = 2'h3;
		`WAITC(soft_start_ref === SS_REF_MAX)
		`CHK("ramp", 1'b1, wt >= SS * 7 / 10 && wt <= SS * 13 / 10)
		seen = 1'b0;
		repeat (300) begin
			seen |= low_side_on;
			@(negedge ref_clk);
		end
		`CHK("rectifier off", 1'b0, seen)
		prebias = 1'b1;
		pulse(1, a);
		`CHK("first low width", LS_START_CYC, 16'(a))
		pulse(1, a);
		`CHK("second low width", LS_START_CYC + LS_STEP_CYC, 16'(a))
	endtask

	// On-time follows output over input at two operating points.
	task automatic t_ontime;
		pulse(0, a);
		pulse(0, a);
		`CHK("on time", PERIOD_CYC * 32 / 96, a)
		{vin_code, vout_code} = 16'hC010;
		pulse(0, a);
		pulse(0, a);
		`CHK("on time", PERIOD_CYC * 16 / 192, a)
		{vin_code, vout_code} = 16'h6020;
		pulse(0, a);
	endtask

	// Seven limited cycles lower the limit; one clean cycle restores it.
	task automatic t_overcurrent;
		pulse(0, a);
		overload = 1'b1;
		// A clean low phase would have ended after about 43 cycles.
		repeat (46) @(negedge ref_clk);
		`CHK("low side held", 2'h1, {high_side_on, low_side_on})
		for (int i = 1; i <= 7; i++) begin
			pulse(0, a);
			if (i == 1) `CHK("fixed on time", FIXED_ON_CYC, a)
			if (i == 6) `CHK("limit level", 1'b0, current_limit_level)
		end
		`CHK("limit level", 1'b1, current_limit_level)
		overload = 1'b0;
		pulse(0, a);
		pulse(0, a);
		`CHK("limit level", 1'b0, current_limit_level)
		`CHK("on time", PERIOD_CYC * 32 / 96, a)
	endtask

	// Undervoltage in regulation, hiccup length, then a short during the ramp.
	task automatic t_uv;
		shorted = 1'b1;
		`WAITC(hiccup_active === 1'b1)
		`CHK("uv delay", 1'b1, wt >= UV_DEB_CYC && wt <= UV_DEB_CYC + 6)
		shorted = 1'b0;
		`WAITC(hiccup_active === 1'b0)
		`CHK("hiccup off", 1'b1, wt >= HOFF - 1 && wt <= HOFF + 1)
		`CHK("restart ref", 8'h00, soft_start_ref)
		shorted = 1'b1;
		`WAITC(hiccup_active === 1'b1)
		`CHK("short delay", 1'b1, wt >= HDLY && wt <= HDLY + 6)
		shorted = 1'b0;
		pulse(0, a);
	endtask

	// Supply loss and enable loss both stop the converter without latching.
	task automatic t_lockout;
		for (int i = 0; i < 2; i++) begin
			if (i == 0) supply_ok = 1'b0;
			else enable = 1'b0;
			repeat (5) @(negedge ref_clk);
			`CHK("shut off", 3'h0, {converter_on, high_side_on, low_side_on})
			{enable, supply_ok} = 2'h3;
			`WAITC(converter_on === 1'b1)
			`CHK("restart", 1'b1, wt <= 8)
		end
	endtask

	initial begin
		repeat (5) @(negedge ref_clk);
		arst_n = 1'b1;
		`CHK("idle outputs", 15'h0003, {high_side_on, low_side_on, soft_start_ref,
			current_limit_level, hiccup_active, converter_on, scl_clean, sda_clean})
		t_filter();
		t_start();
		t_ontime();
		t_overcurrent();
		t_uv();
		t_lockout();
		end_sim();
	end
endmodule
